// ---- tb/chip_reset_controller_tb.sv ----
// Self-checking bench for the reset controller.
`define CHK(a, e) begin \
   checks++; \
   if ((a) !== (e)) begin \
      n_errors++; \
      $display("Error at %0t ns: got %0h, expected %0h", $time, a, e); \
   end \
end

module chip_reset_controller_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, rstn = 1'h0, por_req = 1'h0;
   logic ext_hard = 1'h0, ext_soft = 1'h0, status_clear = 1'h0;
   logic wdog_expired = 1'h0, wdog_enable = 1'h1, bus_mon_timeout = 1'h0;
   logic bus_mon_enable = 1'h1, core_checkstop = 1'h0, jtag_soft_req = 1'h0;
   logic checkstop_reset_enable = 1'h1, sw_hard_req = 1'h0;
   logic sw_soft_req = 1'h0, input_clock_halve_select = 1'h0;
   logic boot_memory_space_sel = 1'h0;
   logic [2:0] cfg_source_pins = 3'h0;
   logic [7:0] dly = 8'h08;
   logic power_on_reset_in_n, hard_reset_line_in_n, soft_reset_line_in_n;
   logic cfg_low_loaded, cfg_all_loaded, sys_pll_locked, core_pll_locked;
   logic hard_reset_line_out, hard_reset_line_oe, soft_reset_line_out;
   logic soft_reset_line_oe, cfg_load_start, clock_distribute_en;
   logic system_clock_in_halve_sampled, por_domain_rst_n, hard_domain_rst_n;
   logic soft_domain_rst_n, core_rst_n, exception_prefix_bit;
   logic boot_seq_release;
   logic [2:0] cfg_source_sampled;
   crc_pkg::crc_cause_t reset_status_reg;
   int checks = 0, n_errors = 0, n_load = 0, seed;

   chip_reset_controller u_dut (.*);
   crc_board_model u_board (.*);

   always #20 clk = ~clk;
   always @(posedge clk) if (cfg_load_start === 1'h1) n_load <= n_load + 1;

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // Wait until the OR of both line drives equals lvl; running out is a mismatch.
   task automatic wait_lines(input logic lvl, input int lim);
      for (int k = 0; k < lim; k++) begin
         @(posedge clk);
         #1;
         if ((hard_reset_line_oe | soft_reset_line_oe) === lvl) return;
      end
      n_errors++;
      print_verdict();
   endtask : wait_lines

   task automatic set_cause(input int i, input logic v);
      case (i)
         1: ext_hard <= v;
         2: ext_soft <= v;
         3: wdog_expired <= v;
         4: bus_mon_timeout <= v;
         5: core_checkstop <= v;
         6: jtag_soft_req <= v;
         7: sw_hard_req <= v;
         default: sw_soft_req <= v;
      endcase
   endtask : set_cause

   function automatic logic is_hard(input int i);
      return i inside {1, 3, 4, 5, 7};
   endfunction : is_hard

   task automatic power_on();
      por_req <= 1'h1;
      @(posedge clk);
      por_req <= 1'h0;
   endtask : power_on

   task automatic run_cause(input int i);
      int n0;
      logic h;
      n0 = n_load;
      h = is_hard(i);
      set_cause(i, 1'h1);
      wait_lines(1'h1, 40);
      @(posedge clk);
      set_cause(i, 1'h0);
      #1;
      `CHK(hard_reset_line_oe, h)
      `CHK(soft_reset_line_oe, 1'h1)
      `CHK(por_domain_rst_n, 1'h1)
      `CHK(hard_domain_rst_n, ~h)
      `CHK(core_rst_n, 1'h0)
      wait_lines(1'h0, 2000);
      `CHK(n_load - n0, int'(h))
      `CHK(reset_status_reg, crc_pkg::crc_cause_t'(9'h001 << i))
      `CHK(boot_seq_release, 1'h1)
      `CHK(soft_domain_rst_n & core_rst_n, 1'h1)
      // An external pull inside the guard window must be ignored.
      @(posedge clk);
      ext_soft <= 1'h1;
      repeat (6) @(posedge clk);
      ext_soft <= 1'h0;
      repeat (24) @(posedge clk);
      #1;
      `CHK(soft_reset_line_oe, 1'h0)
   endtask : run_cause

   initial begin
      seed = $urandom(7204);
      repeat (4) @(posedge clk);
      rstn <= 1'h1;
      repeat (3) @(posedge clk);
      cfg_source_pins <= 3'($urandom);
      input_clock_halve_select <= 1'($urandom);
      boot_memory_space_sel <= 1'($urandom);
      dly <= 8'($urandom_range(1, 40));
      power_on();
      wait_lines(1'h1, 60);
      wait_lines(1'h0, 3000);
      `CHK(reset_status_reg, 9'h001)
      `CHK(cfg_source_sampled, cfg_source_pins)
      `CHK(system_clock_in_halve_sampled, input_clock_halve_select)
      `CHK(exception_prefix_bit, boot_memory_space_sel)
      `CHK(clock_distribute_en, 1'h1)
      `CHK({por_domain_rst_n, hard_domain_rst_n}, 2'h3)
      repeat (20) @(posedge clk);
      {wdog_enable, bus_mon_enable, checkstop_reset_enable} <= 3'h0;
      for (int i = 3; i <= 5; i++) set_cause(i, 1'h1);
      repeat (30) @(posedge clk);
      #1;
      `CHK(soft_reset_line_oe, 1'h0)
      @(posedge clk);
      for (int i = 3; i <= 5; i++) set_cause(i, 1'h0);
      repeat (4) @(posedge clk);
      {wdog_enable, bus_mon_enable, checkstop_reset_enable} <= 3'h7;
      for (int i = 1; i <= 8; i++) begin
         @(posedge clk);
         run_cause(i);
      end
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         dly <= 8'($urandom_range(1, 40));
         run_cause($urandom_range(1, 8));
      end
      @(posedge clk);
      status_clear <= 1'h1;
      @(posedge clk);
      status_clear <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(reset_status_reg, 9'h000)
      // Power-on arriving in the middle of a soft flow takes over.
      @(posedge clk);
      sw_soft_req <= 1'h1;
      wait_lines(1'h1, 40);
      @(posedge clk);
      sw_soft_req <= 1'h0;
      power_on();
      repeat (10) @(posedge clk);
      #1;
      `CHK(hard_reset_line_oe, 1'h1)
      wait_lines(1'h0, 3000);
      `CHK(reset_status_reg, 9'h001)
      print_verdict();
   end
endmodule : chip_reset_controller_tb

// ---- tb/crc_board_model.sv ----
// Board side: power-on supervisor, pulled-up lines, word loader and PLLs.
module crc_board_model (
   // Bench requests
   input wire logic       clk,
   input wire logic       por_req,
   input wire logic       ext_hard,
   input wire logic       ext_soft,
   input wire logic [7:0] dly,
   // Device side
   input wire logic       hard_reset_line_oe,
   input wire logic       soft_reset_line_oe,
   input wire logic       cfg_load_start,
   input wire logic       clock_distribute_en,
   output logic           power_on_reset_in_n,
   output logic           hard_reset_line_in_n,
   output logic           soft_reset_line_in_n,
   output logic           cfg_low_loaded,
   output logic           cfg_all_loaded,
   output logic           sys_pll_locked,
   output logic           core_pll_locked
);
   timeunit 1ns;
   timeprecision 1ns;
   int por_cnt = 0;
   int ld_cnt = 0;
   int sp_cnt = 0;
   int cp_cnt = 0;
   // Pull-ups bring a released line high.
   assign hard_reset_line_in_n = !(hard_reset_line_oe | ext_hard);
   assign soft_reset_line_in_n = !(soft_reset_line_oe | ext_soft);
   // Test reset shares this pin, so both negate together.
   assign power_on_reset_in_n  = (por_cnt == 0);
   assign cfg_low_loaded       = (ld_cnt > dly);
   assign cfg_all_loaded       = (ld_cnt > 2 * dly);
   assign sys_pll_locked       = (sp_cnt > dly);
   assign core_pll_locked      = (cp_cnt > dly);
   always @(posedge clk) begin
      if (por_req) begin
         por_cnt <= 40;
      end else if (por_cnt != 0) begin
         por_cnt <= por_cnt - 1;
      end
      if (por_cnt != 0) begin
         ld_cnt <= 0;
         sp_cnt <= 0;
         cp_cnt <= 0;
      end else begin
         // A slow loader is the usual case, so delays follow dly.
         if (cfg_load_start) begin
            ld_cnt <= 1;
         end else if (ld_cnt != 0) begin
            ld_cnt <= ld_cnt + 1;
         end
         if (cfg_low_loaded) begin
            sp_cnt <= sp_cnt + 1;
         end
         if (clock_distribute_en) begin
            cp_cnt <= cp_cnt + 1;
         end
      end
   end
endmodule : crc_board_model

// ---- tb/crc_reset_properties.sv ----
// Concurrent checks on the ports of the reset controller.
module crc_reset_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // Reset lines and causes
   input wire logic       power_on_reset_in_n,
   input wire logic       hard_reset_line_in_n,
   input wire logic       hard_reset_line_out,
   input wire logic       hard_reset_line_oe,
   input wire logic       soft_reset_line_out,
   input wire logic       soft_reset_line_oe,
   input wire logic       wdog_expired,
   input wire logic       wdog_enable,
   input wire logic       bus_mon_timeout,
   input wire logic       bus_mon_enable,
   input wire logic       core_checkstop,
   input wire logic       checkstop_reset_enable,
   input wire logic       sw_hard_req,
   // Configuration
   input wire logic [2:0] cfg_source_pins,
   input wire logic       input_clock_halve_select,
   input wire logic       cfg_load_start,
   input wire logic       cfg_all_loaded,
   input wire logic       core_pll_locked,
   input wire logic [2:0] cfg_source_sampled,
   input wire logic       system_clock_in_halve_sampled,
   // Fan-out
   input wire logic       por_domain_rst_n,
   input wire logic       hard_domain_rst_n,
   input wire logic       core_rst_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] soft_cnt_r;
   logic [9:0] soft_cnt_nxt;
   logic       hard_seen_r;
   logic       hard_seen_nxt;
   logic       hard_cause;
   // The length check is skipped once hard drive joined the soft pulse.
   assign hard_cause = !power_on_reset_in_n | !hard_reset_line_in_n
      | (wdog_expired & wdog_enable) | (bus_mon_timeout & bus_mon_enable)
      | (core_checkstop & checkstop_reset_enable) | sw_hard_req;
   always_comb begin
      soft_cnt_nxt  = soft_reset_line_oe ? soft_cnt_r + 10'h001 : 10'h000;
      hard_seen_nxt = soft_reset_line_oe & (hard_seen_r | hard_reset_line_oe);
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         soft_cnt_r  <= 10'h000;
         hard_seen_r <= 1'h0;
      end else begin
         soft_cnt_r  <= soft_cnt_nxt;
         hard_seen_r <= hard_seen_nxt;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_por_held;
      !power_on_reset_in_n [*6];
   endsequence
   sequence s_por_quiet;
      power_on_reset_in_n [*4];
   endsequence
   sequence s_lines_idle;
      (!soft_reset_line_oe && !hard_reset_line_oe) [*8];
   endsequence
   a_soft_with_hard: assert property (hard_reset_line_oe |-> soft_reset_line_oe)
      else $error("Hard line driven without soft line.");
   a_open_drain: assert property (!hard_reset_line_out && !soft_reset_line_out)
      else $error("Reset line driven high.");
   a_hard_cause: assert property ($rose(hard_reset_line_oe) |-> $past(hard_cause, 3))
      else $error("Hard drive without a hard cause.");
   a_por_drives: assert property (s_por_held |-> hard_reset_line_oe && soft_reset_line_oe)
      else $error("Power-on held without both lines driven.");
   a_hold_hard: assert property (hard_reset_line_oe && !(core_pll_locked && cfg_all_loaded) |=> hard_reset_line_oe)
      else $error("Hard line released before lock and load.");
   a_release_16: assert property ($fell(hard_reset_line_oe) |-> $past(core_pll_locked && cfg_all_loaded, 16))
      else $error("Hard release not 16 clocks after lock and load.");
   a_load_pulse: assert property (cfg_load_start |=> !cfg_load_start)
      else $error("Load start longer than one cycle.");
   a_cfg_sampled: assert property ($rose(cfg_load_start) |-> cfg_source_sampled == cfg_source_pins && system_clock_in_halve_sampled == input_clock_halve_select)
      else $error("Straps not sampled.");
   a_core_in_soft: assert property (soft_reset_line_oe |-> !core_rst_n)
      else $error("Core out of reset while soft line driven.");
   a_soft_len: assert property ($fell(soft_reset_line_oe) && !hard_seen_r |-> soft_cnt_r == 10'h200)
      else $error("Soft drive length wrong.");
   a_por_domain: assert property (s_por_quiet ##0 por_domain_rst_n |=> por_domain_rst_n)
      else $error("Power-on domain reset without power-on.");
   a_soft_keeps_hard: assert property (soft_reset_line_oe && !hard_reset_line_oe && $past(soft_reset_line_oe && !hard_reset_line_oe) |-> hard_domain_rst_n)
      else $error("Hard domain reset by a soft flow.");
   a_guard_quiet: assert property ($fell(soft_reset_line_oe) && power_on_reset_in_n |=> s_lines_idle)
      else $error("New reset inside guard window.");
endmodule : crc_reset_properties

bind chip_reset_controller crc_reset_properties u_props (.*);

// ---- verilog/chip_reset_controller.sv ----
// Central reset controller: cause capture, sequencing and reset fan-out.
`include "crc_defs.svh"

// Functional notes
// - Nine causes accepted; action chosen per cause.
// - Status register records causes of last reset.
// - External hard line sensed only when undriven.
// - Soft line driven whenever hard line driven.
// - External soft sensed only when neither driven.
// - Enabled watchdog expiry starts hard sequence.
// - Enabled bus monitor timeout starts hard sequence.
// - Checkstop resets only when enable bit set.
// - JTAG soft request runs soft sequence.
// - Software control write starts hard or soft.
// - Synchronise causes, reset only matching class.
// - Core reset always; prefix from boot space.
// - Clock, RTC, error capture: power-on only.
// - Memory, timers, windows: power-on and hard.
// - Config reload power-on/hard; other logic always.
// - Sample config pins at power-on release.
// - Both lines driven throughout power-on sequence.
// - Config low, system PLL, then core PLL.
// - Release hard 16 clocks after lock+load.
// - With hard, release soft, core, boot sequencer.
// - Soft reset drives soft line 512 clocks.
// - Wait 16 cycles before sensing lines again.
module chip_reset_controller (
   // Clock and power-on reset
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              power_on_reset_in_n,
   // Open-drain reset lines
   input  wire logic              hard_reset_line_in_n,
   output logic                   hard_reset_line_out,
   output logic                   hard_reset_line_oe,
   input  wire logic              soft_reset_line_in_n,
   output logic                   soft_reset_line_out,
   output logic                   soft_reset_line_oe,
   // Internal cause sources
   input  wire logic              wdog_expired,
   input  wire logic              wdog_enable,
   input  wire logic              bus_mon_timeout,
   input  wire logic              bus_mon_enable,
   input  wire logic              core_checkstop,
   input  wire logic              checkstop_reset_enable,
   input  wire logic              jtag_soft_req,
   input  wire logic              sw_hard_req,
   input  wire logic              sw_soft_req,
   // Configuration pins and loader handshake
   input  wire logic [2:0]        cfg_source_pins,
   input  wire logic              input_clock_halve_select,
   output logic                   cfg_load_start,
   input  wire logic              cfg_low_loaded,
   input  wire logic              cfg_all_loaded,
   input  wire logic              boot_memory_space_sel,
   input  wire logic              sys_pll_locked,
   input  wire logic              core_pll_locked,
   output logic                   clock_distribute_en,
   // Status
   input  wire logic              status_clear,
   output crc_pkg::crc_cause_t    reset_status_reg,
   output logic [2:0]             cfg_source_sampled,
   output logic                   system_clock_in_halve_sampled,
   // Reset fan-out, active low; prefix bit and boot release active high
   output logic                   por_domain_rst_n,
   output logic                   hard_domain_rst_n,
   output logic                   soft_domain_rst_n,
   output logic                   core_rst_n,
   output logic                   exception_prefix_bit,
   output logic                   boot_seq_release
);
   import crc_pkg::*;

   // ****************************************************************
   // Cause synchronisation
   // ****************************************************************
   crc_sync_if sif ();
   logic [8:0] cause_s;

   assign sif.raw = {sw_soft_req, sw_hard_req, jtag_soft_req,
                     core_checkstop, bus_mon_timeout, wdog_expired,
                     ~soft_reset_line_in_n, ~hard_reset_line_in_n,
                     ~power_on_reset_in_n};

   crc_sync #(.WIDTH(9)) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .sif  (sif)
   );
   assign cause_s = sif.sync;

   // Enables sit on the same clock, so they gate the synchronised levels.
   logic por_s;
   logic ext_hr;
   logic ext_sr;
   logic hard_ev;
   logic soft_ev;
   logic [8:0] hit;

   // ****************************************************************
   // State
   // ****************************************************************
   crc_state_e  st_r, st_nxt;
   logic        drv_h_r, drv_h_nxt;
   logic        drv_s_r, drv_s_nxt;
   logic        por_flow_r, por_flow_nxt;
   logic        hard_flow_r, hard_flow_nxt;
   crc_cause_t  stat_r, stat_nxt;
   logic [2:0]  src_r, src_nxt;
   logic        halve_r, halve_nxt;
   logic        ld_r, ld_nxt;
   logic        clk_en_r, clk_en_nxt;
   logic        rst_por_r, rst_por_nxt;
   logic        rst_hard_r, rst_hard_nxt;
   logic        rst_soft_r, rst_soft_nxt;
   logic        ip_r, ip_nxt;
   logic        boot_r, boot_nxt;
   logic        cnt_load;
   logic [`CRC_CNT_W-1:0] cnt_val;
   logic        cnt_done;

   crc_counter #(.W(`CRC_CNT_W)) u_cnt (
      .clk   (clk),
      .rstn  (rstn),
      .load  (cnt_load),
      .value (cnt_val),
      .done  (cnt_done)
   );

   always_comb begin
      por_s   = cause_s[`CRC_ST_POR];
      ext_hr  = cause_s[`CRC_ST_EXT_HR] && !drv_h_r;
      ext_sr  = cause_s[`CRC_ST_EXT_SR] && !drv_h_r && !drv_s_r;
      hit     = '0;
      hit[`CRC_ST_EXT_HR] = ext_hr;
      hit[`CRC_ST_EXT_SR] = ext_sr;
      hit[`CRC_ST_WDOG]   = cause_s[`CRC_ST_WDOG] && wdog_enable;
      hit[`CRC_ST_BMON]   = cause_s[`CRC_ST_BMON] && bus_mon_enable;
      hit[`CRC_ST_CHKS]   = cause_s[`CRC_ST_CHKS]
                            && checkstop_reset_enable;
      hit[`CRC_ST_JTAG]   = cause_s[`CRC_ST_JTAG];
      hit[`CRC_ST_SW_HR]  = cause_s[`CRC_ST_SW_HR];
      hit[`CRC_ST_SW_SR]  = cause_s[`CRC_ST_SW_SR];
      // External lines are ignored until the guard interval has passed.
      if (st_r != CRC_IDLE) begin
         hit[`CRC_ST_EXT_HR] = 1'b0;
         hit[`CRC_ST_EXT_SR] = 1'b0;
      end
      hard_ev = hit[`CRC_ST_EXT_HR] | hit[`CRC_ST_WDOG] | hit[`CRC_ST_BMON]
                | hit[`CRC_ST_CHKS] | hit[`CRC_ST_SW_HR];
      soft_ev = hit[`CRC_ST_EXT_SR] | hit[`CRC_ST_JTAG]
                | hit[`CRC_ST_SW_SR];
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_comb begin
      st_nxt        = st_r;
      drv_h_nxt     = drv_h_r;
      drv_s_nxt     = drv_s_r;
      por_flow_nxt  = por_flow_r;
      hard_flow_nxt = hard_flow_r;
      stat_nxt      = stat_r;
      src_nxt       = src_r;
      halve_nxt     = halve_r;
      ld_nxt        = 1'b0;
      clk_en_nxt    = clk_en_r;
      rst_por_nxt   = rst_por_r;
      rst_hard_nxt  = rst_hard_r;
      rst_soft_nxt  = rst_soft_r;
      ip_nxt        = ip_r;
      boot_nxt      = boot_r;
      cnt_load      = 1'b0;
      cnt_val       = '0;
      if (status_clear) begin
         stat_nxt = '0;
      end
      if (por_s) begin
         // Power-on holds everything; all domains and clocks in reset.
         st_nxt       = CRC_CFG;
         drv_h_nxt    = 1'b1;
         drv_s_nxt    = 1'b1;
         por_flow_nxt = 1'b1;
         hard_flow_nxt = 1'b1;
         stat_nxt     = `CRC_ST_RESET;
         clk_en_nxt   = 1'b0;
         rst_por_nxt  = 1'b1;
         rst_hard_nxt = 1'b1;
         rst_soft_nxt = 1'b1;
         boot_nxt     = 1'b0;
         src_nxt      = cfg_source_pins;
         halve_nxt    = input_clock_halve_select;
      end else begin
         case (st_r)
            CRC_IDLE: begin
               if (hard_ev) begin
                  // Set wins over software clear for new causes.
                  stat_nxt      = hit;
                  st_nxt        = CRC_CFG;
                  drv_h_nxt     = 1'b1;
                  drv_s_nxt     = 1'b1;
                  hard_flow_nxt = 1'b1;
                  rst_hard_nxt  = 1'b1;
                  rst_soft_nxt  = 1'b1;
                  boot_nxt      = 1'b0;
               end else if (soft_ev) begin
                  stat_nxt     = hit;
                  st_nxt       = CRC_SOFT;
                  drv_s_nxt    = 1'b1;
                  rst_soft_nxt = 1'b1;
                  boot_nxt     = 1'b0;
                  cnt_load     = 1'b1;
                  cnt_val      = `CRC_CNT_W'(`CRC_SOFT_DRIVE_CLK);
               end
            end
            CRC_CFG: begin
               // Release the power-on domain; ask the loader to start.
               rst_por_nxt = 1'b0;
               ld_nxt      = 1'b1;
               st_nxt      = por_flow_r ? CRC_SPLL : CRC_CPLL;
            end
            CRC_SPLL: begin
               if (cfg_low_loaded && sys_pll_locked) begin
                  clk_en_nxt = 1'b1;
                  st_nxt     = CRC_CPLL;
               end
            end
            CRC_CPLL: begin
               // Loader flags lag the start pulse a cycle, so skip them then.
               if (core_pll_locked && cfg_all_loaded && !ld_r
                   && (clk_en_r || !por_flow_r)) begin
                  cnt_load = 1'b1;
                  cnt_val  = `CRC_CNT_W'(`CRC_HARD_RELEASE_CLK);
                  st_nxt   = CRC_HREL;
               end
            end
            CRC_HREL: begin
               if (cnt_done) begin
                  drv_h_nxt     = 1'b0;
                  drv_s_nxt     = 1'b0;
                  rst_hard_nxt  = 1'b0;
                  rst_soft_nxt  = 1'b0;
                  ip_nxt        = boot_memory_space_sel;
                  boot_nxt      = 1'b1;
                  por_flow_nxt  = 1'b0;
                  hard_flow_nxt = 1'b0;
                  st_nxt        = CRC_GUARD;
                  cnt_load      = 1'b1;
                  cnt_val       = `CRC_CNT_W'(`CRC_GUARD_CLK);
               end
            end
            CRC_SOFT: begin
               if (cnt_done) begin
                  drv_s_nxt    = 1'b0;
                  rst_soft_nxt = 1'b0;
                  ip_nxt       = boot_memory_space_sel;
                  boot_nxt     = 1'b1;
                  st_nxt       = CRC_GUARD;
                  cnt_load     = 1'b1;
                  cnt_val      = `CRC_CNT_W'(`CRC_GUARD_CLK);
               end
            end
            CRC_GUARD: begin
               // Count only once the pulled-up lines read negated.
               if (cause_s[`CRC_ST_EXT_HR] || cause_s[`CRC_ST_EXT_SR]) begin
                  cnt_load = 1'b1;
                  cnt_val  = `CRC_CNT_W'(`CRC_GUARD_CLK);
               end else if (cnt_done) begin
                  st_nxt = CRC_IDLE;
               end
            end
            default: begin
               st_nxt = CRC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_r        <= CRC_IDLE;
         drv_h_r     <= 1'b0;
         drv_s_r     <= 1'b0;
         por_flow_r  <= 1'b0;
         hard_flow_r <= 1'b0;
         stat_r      <= `CRC_ST_RESET;
         src_r       <= 3'h0;
         halve_r     <= 1'b0;
         ld_r        <= 1'b0;
         clk_en_r    <= 1'b0;
         rst_por_r   <= 1'b1;
         rst_hard_r  <= 1'b1;
         rst_soft_r  <= 1'b1;
         ip_r        <= 1'b0;
         boot_r      <= 1'b0;
      end else begin
         st_r        <= st_nxt;
         drv_h_r     <= drv_h_nxt;
         drv_s_r     <= drv_s_nxt;
         por_flow_r  <= por_flow_nxt;
         hard_flow_r <= hard_flow_nxt;
         stat_r      <= stat_nxt;
         src_r       <= src_nxt;
         halve_r     <= halve_nxt;
         ld_r        <= ld_nxt;
         clk_en_r    <= clk_en_nxt;
         rst_por_r   <= rst_por_nxt;
         rst_hard_r  <= rst_hard_nxt;
         rst_soft_r  <= rst_soft_nxt;
         ip_r        <= ip_nxt;
         boot_r      <= boot_nxt;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Open-drain: the line is only ever pulled low, never driven high.
   assign hard_reset_line_out  = 1'b0;
   assign hard_reset_line_oe   = drv_h_r;
   assign soft_reset_line_out  = 1'b0;
   assign soft_reset_line_oe   = drv_s_r;
   assign cfg_load_start       = ld_r;
   assign clock_distribute_en  = clk_en_r;
   assign reset_status_reg     = stat_r;
   assign cfg_source_sampled   = src_r;
   assign system_clock_in_halve_sampled  = halve_r;
   assign por_domain_rst_n     = ~rst_por_r;
   assign hard_domain_rst_n    = ~rst_hard_r;
   assign soft_domain_rst_n    = ~rst_soft_r;
   assign core_rst_n           = ~rst_soft_r;
   assign exception_prefix_bit = ip_r;
   assign boot_seq_release     = boot_r;
endmodule : chip_reset_controller

// ---- verilog/crc_counter.sv ----
// Down counter used for the release, soft-drive and guard intervals.
module crc_counter #(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   // Status
   output logic              done
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;

   initial begin
      if (W < 10) $error("crc_counter W must hold 512");
   end

   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = value;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1});
endmodule : crc_counter

// ---- verilog/crc_defs.svh ----
// Timing counts, field positions and reset values of the reset controller.
`ifndef CRC_DEFS_SVH
`define CRC_DEFS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CRC_CLK_MHZ          25
`define CRC_HARD_RELEASE_CLK 16
`define CRC_SOFT_DRIVE_CLK   512
`define CRC_GUARD_CLK        16
`define CRC_CNT_W            10

// ****************************************************************
// Status bit positions
// ****************************************************************
`define CRC_ST_POR    0
`define CRC_ST_EXT_HR 1
`define CRC_ST_EXT_SR 2
`define CRC_ST_WDOG   3
`define CRC_ST_BMON   4
`define CRC_ST_CHKS   5
`define CRC_ST_JTAG   6
`define CRC_ST_SW_HR  7
`define CRC_ST_SW_SR  8
`define CRC_ST_W      9
`define CRC_ST_RESET  9'h001

`endif

// ---- verilog/crc_pkg.sv ----
// Types shared by the reset controller modules.
package crc_pkg;

   typedef enum logic [6:0] {
      CRC_IDLE  = 7'h01,
      CRC_CFG   = 7'h02,
      CRC_SPLL  = 7'h04,
      CRC_CPLL  = 7'h08,
      CRC_HREL  = 7'h10,
      CRC_SOFT  = 7'h20,
      CRC_GUARD = 7'h40
   } crc_state_e;

   typedef logic [8:0] crc_cause_t;

endpackage : crc_pkg

// ---- verilog/crc_sync.sv ----
// Two-flop synchronisers, one per asynchronous cause.
module crc_sync #(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Cause levels
   crc_sync_if.src   sif
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   initial begin
      if (WIDTH != 9) $error("crc_sync WIDTH must be 9");
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_comb begin
            meta_nxt[i] = sif.raw[i];
            sync_nxt[i] = meta_r[i];
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sif.sync = sync_r;
endmodule : crc_sync

// ---- verilog/crc_sync_if.sv ----
// Bundle of synchronised cause levels between the synchroniser and the top.
interface crc_sync_if;
   logic [8:0] raw;
   logic [8:0] sync;
   modport src (input raw, output sync);
   modport dst (output raw, input sync);
endinterface : crc_sync_if
